// file: adc_pin_consts.vh
`ifndef ADC_PIN_CONSTS_VH
`define ADC_PIN_CONSTS_VH
// timing
`define CLK_PERIOD_NS 40
`define POWERUP_TIME_NS 1000
`define POWERUP_CYCLES ((`POWERUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_TIME_NS 2000
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// bus addresses
`define ADDR_V0_LOW 7'h21
`define ADDR_V0_HIGH 7'h22
`define ADDR_V1_LOW 7'h23
`define ADDR_V1_HIGH 7'h24
`define ADDR_FLOAT 7'h20
// register offsets
`define OFF_CONFIG 4'h0
`define OFF_RESULT 4'h1
`define OFF_HIGH_LIMIT 4'h2
`define OFF_LOW_LIMIT 4'h3
`define OFF_STATUS 4'h4
`define OFF_MASK 4'h5
`define OFF_ADDRESS 4'h6
// config fields
`define CFG_ALERT_EN 0
`define CFG_BUSY_MODE 1
`define CFG_CHANNEL_MODE 6
`define CFG_CHAN_SEL 7
`define CFG_RESET 8'h00
`define HIGH_LIMIT_RESET 12'hfff
`define LOW_LIMIT_RESET 12'h000
// status fields
`define ST_DONE 0
`define ST_ALARM 1
`define ST_SHORT 2
`endif

// file: sar_model.v
`timescale 1ns/1ns
`include "adc_pin_consts.vh"
module sar_model #(
  parameter WIDTH = 12,
  parameter CONV_CYCLES = `CONV_CYCLES
) (
  input wire core_clk,
  input wire rstn,
  input wire start,
  input wire [WIDTH-1:0] sample,
  output reg busy,
  output reg done,
  output reg [WIDTH-1:0] code
);
  // ==========================================================
  // successive approximation sequencer, one bit per step
  reg [7:0] tickCnt_reg;
  reg [WIDTH-1:0] trial_reg;
  reg [WIDTH-1:0] held_reg;
  reg [4:0] bitIdx_reg;
  localparam integer STEP_I = (CONV_CYCLES / WIDTH) < 1 ? 1 : CONV_CYCLES / WIDTH;
  localparam [7:0] STEP = STEP_I[7:0];
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      done <= 1'b0;
      code <= 12'h000;
      tickCnt_reg <= 8'h00;
      trial_reg <= 12'h000;
      held_reg <= 12'h000;
      bitIdx_reg <= 5'h00;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        held_reg <= sample;
        trial_reg <= 12'h000;
        bitIdx_reg <= WIDTH[4:0] - 5'h01;
        tickCnt_reg <= 8'h00;
      end else if (busy) begin
        if (tickCnt_reg == STEP - 8'h01) begin
          tickCnt_reg <= 8'h00;
          if ((trial_reg | (12'h001 << bitIdx_reg)) <= held_reg)
            trial_reg <= trial_reg | (12'h001 << bitIdx_reg);
          if (bitIdx_reg == 5'h00) begin
            busy <= 1'b0;
            done <= 1'b1;
            if ((trial_reg | 12'h001) <= held_reg)
              code <= trial_reg | 12'h001;
            else
              code <= trial_reg;
          end else begin
            bitIdx_reg <= bitIdx_reg - 5'h01;
          end
        end else begin
          tickCnt_reg <= tickCnt_reg + 8'h01;
        end
      end
    end
  end
endmodule // sar_model

// file: adc_conversion_pin_control.v
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "adc_pin_consts.vh"
module adc_conversion_pin_control #(
  parameter PART_VERSION = 0,
  parameter WIDTH = 12,
  parameter POWERUP_CYCLES = `POWERUP_CYCLES,
  parameter CONV_CYCLES = `CONV_CYCLES
) (
  input wire core_clk,
  input wire resetn,
  input wire convertStart,
  input wire addrSelHigh,
  input wire addrSelFloat,
  input wire [WIDTH-1:0] firstAnalogInput,
  input wire [WIDTH-1:0] secondAnalogInput,
  input wire [3:0] regAddr,
  input wire [15:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [15:0] regRdata,
  output wire alertBusyOut,
  output wire alertBusyOe_n,
  output reg [6:0] busAddress,
  output reg converterPowered,
  output reg trackHold,
  output reg useExternalRef,
  output wire irq
);
  // ==========================================================
  // reset release
  // two-stage release so every flop leaves reset on the same edge
  reg rstMeta_reg;
  reg rstn_reg;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_reg <= 1'b0;
      rstn_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstn_reg <= rstMeta_reg;
    end
  end

  // ==========================================================
  // pin synchronisers
  reg [1:0] cs_reg;
  reg csPrev_reg;
  reg [1:0] selHigh_reg;
  reg [1:0] selFloat_reg;
  always @(posedge core_clk or negedge rstn_reg) begin
    if (!rstn_reg) begin
      cs_reg <= 2'h0;
      csPrev_reg <= 1'b0;
      selHigh_reg <= 2'h0;
      selFloat_reg <= 2'h0;
    end else begin
      cs_reg <= {cs_reg[0], convertStart};
      csPrev_reg <= cs_reg[1];
      selHigh_reg <= {selHigh_reg[0], addrSelHigh};
      selFloat_reg <= {selFloat_reg[0], addrSelFloat};
    end
  end
  wire csRise = cs_reg[1] & ~csPrev_reg;
  wire csFall = ~cs_reg[1] & csPrev_reg;

  // ==========================================================
  // analog level synchronisers
  // levels are held steady around a conversion, so a plain two-stage copy is enough
  reg [WIDTH-1:0] firstMeta_reg;
  reg [WIDTH-1:0] firstSync_reg;
  reg [WIDTH-1:0] secondMeta_reg;
  reg [WIDTH-1:0] secondSync_reg;
  always @(posedge core_clk or negedge rstn_reg) begin
    if (!rstn_reg) begin
      firstMeta_reg <= {WIDTH{1'b0}};
      firstSync_reg <= {WIDTH{1'b0}};
      secondMeta_reg <= {WIDTH{1'b0}};
      secondSync_reg <= {WIDTH{1'b0}};
    end else begin
      firstMeta_reg <= firstAnalogInput;
      firstSync_reg <= firstMeta_reg;
      secondMeta_reg <= secondAnalogInput;
      secondSync_reg <= secondMeta_reg;
    end
  end

  // ==========================================================
  // address selection
  function [6:0] pickAddr;
    input isV1;
    input high;
    input flt;
    begin
      if (flt)
        pickAddr = `ADDR_FLOAT;
      else if (isV1)
        pickAddr = high ? `ADDR_V1_HIGH : `ADDR_V1_LOW;
      else
        pickAddr = high ? `ADDR_V0_HIGH : `ADDR_V0_LOW;
    end
  endfunction
  reg addrTaken_reg;
  reg [1:0] settle_reg;
  always @(posedge core_clk or negedge rstn_reg) begin
    if (!rstn_reg) begin
      addrTaken_reg <= 1'b0;
      settle_reg <= 2'h0;
      busAddress <= `ADDR_FLOAT;
    end else if (!addrTaken_reg) begin
      if (settle_reg == 2'h2) begin
        addrTaken_reg <= 1'b1;
        busAddress <= pickAddr(PART_VERSION != 0, selHigh_reg[1], selFloat_reg[1]);
      end else begin
        settle_reg <= settle_reg + 2'h1;
      end
    end
  end

  // ==========================================================
  // registers
  reg [7:0] config_reg;
  reg [WIDTH-1:0] highLimit_reg;
  reg [WIDTH-1:0] lowLimit_reg;
  reg [WIDTH-1:0] result_reg;
  reg [2:0] status_reg;
  reg [2:0] mask_reg;
  reg [2:0] events;
  wire wrStatus = regWrite && regAddr == `OFF_STATUS;
  // limit check shared by the alarm pin and the alarm status bit
  function outOfLimits;
    input [WIDTH-1:0] value;
    input [WIDTH-1:0] upper;
    input [WIDTH-1:0] lower;
    begin
      outOfLimits = (value > upper) || (value < lower);
    end
  endfunction

  // ==========================================================
  // power and conversion sequencer
  localparam [3:0] ST_DOWN = 4'h1;
  localparam [3:0] ST_POWERING = 4'h2;
  localparam [3:0] ST_READY = 4'h4;
  localparam [3:0] ST_CONVERT = 4'h8;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [15:0] pwrCnt_reg;
  reg shortPulse_reg;
  wire convBusy;
  wire convDone;
  wire [WIDTH-1:0] convCode;
  wire startConv = (state_reg == ST_POWERING || state_reg == ST_READY) && csFall;
  reg [WIDTH-1:0] selInput;
  // single-channel mode always converts the first input, the second pin is the reference
  always @* begin
    if (config_reg[`CFG_CHANNEL_MODE]) begin
      selInput = firstSync_reg;
    end else if (config_reg[`CFG_CHAN_SEL]) begin
      selInput = secondSync_reg;
    end else begin
      selInput = firstSync_reg;
    end
  end
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_DOWN: begin
        // falls seen while powered down are ignored
        if (csRise)
          state_next = ST_POWERING;
      end
      ST_POWERING: begin
        if (csFall)
          state_next = ST_CONVERT;
        else if (pwrCnt_reg == POWERUP_CYCLES[15:0] - 16'h0001)
          state_next = ST_READY;
      end
      ST_READY: begin
        if (csFall)
          state_next = ST_CONVERT;
      end
      ST_CONVERT: begin
        // pin edges during a conversion are ignored
        if (convDone)
          state_next = ST_DOWN;
      end
      default: state_next = ST_DOWN;
    endcase
  end
  always @(posedge core_clk or negedge rstn_reg) begin
    if (!rstn_reg) begin
      state_reg <= ST_DOWN;
      pwrCnt_reg <= 16'h0000;
      shortPulse_reg <= 1'b0;
      converterPowered <= 1'b0;
      trackHold <= 1'b0;
      useExternalRef <= 1'b0;
      result_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_POWERING)
        pwrCnt_reg <= pwrCnt_reg + 16'h0001;
      else
        pwrCnt_reg <= 16'h0000;
      if (startConv)
        shortPulse_reg <= (state_reg == ST_POWERING);
      converterPowered <= (state_next != ST_DOWN);
      trackHold <= (state_next == ST_CONVERT);
      useExternalRef <= config_reg[`CFG_CHANNEL_MODE];
      if (convDone)
        result_reg <= convCode;
    end
  end

  sar_model #(
    .WIDTH(WIDTH),
    .CONV_CYCLES(CONV_CYCLES)
  ) u_sar (
    .core_clk(core_clk),
    .rstn(rstn_reg),
    .start(startConv),
    .sample(selInput),
    .busy(convBusy),
    .done(convDone),
    .code(convCode)
  );

  // ==========================================================
  // shared output
  reg alarm_reg;
  always @(posedge core_clk or negedge rstn_reg) begin
    if (!rstn_reg) begin
      alarm_reg <= 1'b0;
    end else if (convDone) begin
      alarm_reg <= config_reg[`CFG_ALERT_EN] && outOfLimits(convCode, highLimit_reg, lowLimit_reg);
    end else if (!config_reg[`CFG_ALERT_EN]) begin
      alarm_reg <= 1'b0;
    end
  end
  wire sharedActive = config_reg[`CFG_BUSY_MODE] ? (state_reg == ST_CONVERT) : alarm_reg;
  assign alertBusyOut = 1'b0;
  assign alertBusyOe_n = ~sharedActive;

  // ==========================================================
  // interrupt status
  always @* begin
    events = 3'h0;
    events[`ST_DONE] = convDone;
    events[`ST_ALARM] = convDone && config_reg[`CFG_ALERT_EN] && outOfLimits(convCode, highLimit_reg, lowLimit_reg);
    events[`ST_SHORT] = startConv && state_reg == ST_POWERING;
  end
  always @(posedge core_clk or negedge rstn_reg) begin
    if (!rstn_reg)
      status_reg <= 3'h0;
    else if (wrStatus)
      status_reg <= (status_reg & ~regWdata[2:0]) | events;
    else
      status_reg <= status_reg | events;
  end
  assign irq = |(status_reg & mask_reg);

  // ==========================================================
  // register port
  always @(posedge core_clk or negedge rstn_reg) begin
    if (!rstn_reg) begin
      config_reg <= `CFG_RESET;
      highLimit_reg <= `HIGH_LIMIT_RESET;
      lowLimit_reg <= `LOW_LIMIT_RESET;
      mask_reg <= 3'h0;
      regRdata <= 16'h0000;
    end else begin
      if (regWrite) begin
        case (regAddr)
          `OFF_CONFIG: config_reg <= regWdata[7:0];
          `OFF_HIGH_LIMIT: highLimit_reg <= regWdata[WIDTH-1:0];
          `OFF_LOW_LIMIT: lowLimit_reg <= regWdata[WIDTH-1:0];
          `OFF_MASK: mask_reg <= regWdata[2:0];
          default: ;
        endcase
      end
      regRdata <= 16'h0000;
      if (regRead) begin
        case (regAddr)
          `OFF_CONFIG: regRdata <= {8'h00, config_reg};
          `OFF_RESULT: regRdata <= {3'h0, shortPulse_reg, result_reg};
          `OFF_HIGH_LIMIT: regRdata <= {4'h0, highLimit_reg};
          `OFF_LOW_LIMIT: regRdata <= {4'h0, lowLimit_reg};
          `OFF_STATUS: regRdata <= {8'h00, convBusy, state_reg, status_reg};
          `OFF_MASK: regRdata <= {13'h0000, mask_reg};
          `OFF_ADDRESS: regRdata <= {8'h00, addrTaken_reg, busAddress};
          default: regRdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule // adc_conversion_pin_control

// file: adc_pin_checker.sv
`timescale 1ns/1ns
// ==========================================
// pin-level checker
module adc_pin_checker (
  input wire core_clk,
  input wire resetn,
  input wire convertStart,
  input wire converterPowered,
  input wire trackHold,
  input wire alertBusyOut,
  input wire [6:0] busAddress
);
  logic [3:0] relCnt;
  // cycles since reset release, saturating
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) relCnt <= 4'h0;
    else if (relCnt != 4'hf) relCnt <= relCnt + 4'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_rise_powers_up: assert property ($rose(convertStart) |-> ##[1:5] converterPowered)
    else $error("converter not powered after rising edge");
  a_fall_starts_hold: assert property ($fell(convertStart) && converterPowered && !trackHold |-> ##[1:5] trackHold)
    else $error("no hold after falling edge");
  a_hold_needs_power: assert property ($rose(trackHold) |-> converterPowered)
    else $error("hold while powered down");
  a_conv_ends: assert property ($rose(trackHold) |-> ##[40:70] !trackHold)
    else $error("conversion did not end");
  a_power_down_after: assert property ($fell(trackHold) |-> !converterPowered)
    else $error("still powered after conversion");
  a_one_conv_only: assert property ($fell(trackHold) |-> !trackHold [*8])
    else $error("extra conversion started");
  a_shared_pin_low: assert property (alertBusyOut == 1'b0)
    else $error("open drain data not low");
  a_addr_held: assert property (relCnt == 4'hf |-> $stable(busAddress))
    else $error("bus address changed");
endmodule // adc_pin_checker
bind adc_conversion_pin_control adc_pin_checker chk (.core_clk(core_clk), .resetn(resetn), .convertStart(convertStart),
  .converterPowered(converterPowered), .trackHold(trackHold), .alertBusyOut(alertBusyOut), .busAddress(busAddress));

// file: convert_start_pin_model.sv
`timescale 1ns/1ns
// ==========================================
// convert-start driver on its own 320 ns tick
module convert_start_pin_model (
  input wire go,
  input wire [3:0] ticks,
  output logic pin
);
  logic linkClk = 1'b0;
  int reqCnt = 0;
  int doneCnt = 0;
  int left = 0;
  initial pin = 1'b0;
  initial begin
    #7;
    forever #160 linkClk = ~linkClk;
  end
  always @(posedge go) reqCnt++;
  // high for ticks periods, four ticks clear the power-up time
  always @(posedge linkClk) begin
    if (left > 0) begin
      left <= left - 1;
      if (left == 1) pin <= 1'b0;
    end else if (reqCnt != doneCnt) begin
      doneCnt <= doneCnt + 1;
      pin <= 1'b1;
      left <= ticks;
    end
  end
endmodule // convert_start_pin_model

// file: testbench.sv
`timescale 1ns/1ns
// ==========================================
// bench top
module testbench;
  logic core_clk, resetn, addrSelHigh, addrSelFloat, regWrite, regRead, go;
  logic [11:0] firstIn, secondIn, expCode;
  logic [3:0] regAddr, ticks;
  logic [15:0] regWdata;
  wire [15:0] regRdata;
  wire [6:0] addr0, addr1;
  wire alertOe_n, irq, pwr, hold, extRef, convertStart;
  int n_errors, checked, cycles, i, s, seed;
  adc_conversion_pin_control #(.PART_VERSION(0)) DUT (.core_clk(core_clk), .resetn(resetn), .convertStart(convertStart),
    .addrSelHigh(addrSelHigh), .addrSelFloat(addrSelFloat), .firstAnalogInput(firstIn), .secondAnalogInput(secondIn),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .alertBusyOut(), .alertBusyOe_n(alertOe_n), .busAddress(addr0), .converterPowered(pwr), .trackHold(hold),
    .useExternalRef(extRef), .irq(irq));
  adc_conversion_pin_control #(.PART_VERSION(1)) DUT1 (.core_clk(core_clk), .resetn(resetn), .convertStart(convertStart),
    .addrSelHigh(addrSelHigh), .addrSelFloat(addrSelFloat), .firstAnalogInput(firstIn), .secondAnalogInput(secondIn),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(),
    .alertBusyOut(), .alertBusyOe_n(), .busAddress(addr1), .converterPowered(), .trackHold(),
    .useExternalRef(), .irq());
  convert_start_pin_model link (.go(go), .ticks(ticks), .pin(convertStart));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      give_verdict;
    end
  end
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] x);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(negedge core_clk);
    chk(regRdata & m, x);
  endtask
  task waitHold(input logic v);
    int k;
    k = 0;
    while (hold !== v && k < 300) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 300) chk(16'h0, 16'h1);
  endtask
  task conv(input logic [3:0] t);
    @(posedge core_clk);
    ticks <= t;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    waitHold(1'b1);
  endtask
  task settle;
    waitHold(1'b0);
    repeat (2) @(negedge core_clk);
  endtask
  task doReset;
    resetn <= 1'b0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (10) @(posedge core_clk);
  endtask
  initial begin
    {resetn, addrSelHigh, addrSelFloat, regWrite, regRead, go} = 6'h00;
    {firstIn, secondIn, regAddr, ticks, regWdata} = 48'h0;
    {n_errors, checked, cycles} = 96'h0;
    seed = $urandom(46);
    for (s = 0; s < 3; s++) begin
      addrSelHigh <= (s == 1);
      addrSelFloat <= (s == 2);
      doReset;
      chk({9'h0, addr0}, s == 2 ? 16'h20 : s == 1 ? 16'h22 : 16'h21);
      chk({9'h0, addr1}, s == 2 ? 16'h20 : s == 1 ? 16'h24 : 16'h23);
      addrSelFloat <= (s != 2);
      repeat (3) @(posedge core_clk);
      chk({9'h0, addr0}, s == 2 ? 16'h20 : s == 1 ? 16'h22 : 16'h21);
    end
    // dual channel 0, dual channel 1, single channel
    for (i = 0; i < 3; i++) begin
      firstIn <= 12'($urandom);
      secondIn <= 12'($urandom);
      wr(4'h0, i == 0 ? 16'h0000 : i == 1 ? 16'h0080 : 16'h0040);
      conv(4'h4);
      expCode = (i == 1) ? secondIn : firstIn;
      chk({15'h0, extRef}, {15'h0, i == 2});
      chk({15'h0, pwr}, 16'h1);
      chk({15'h0, alertOe_n}, 16'h1);
      settle;
      chk({15'h0, pwr}, 16'h0);
      rd(4'h1, 16'h1fff, {4'h0, expCode});
    end
    conv(4'h1);
    settle;
    rd(4'h1, 16'h1000, 16'h1000);
    wr(4'h0, 16'h0002);
    conv(4'h4);
    chk({15'h0, alertOe_n}, 16'h0);
    settle;
    chk({15'h0, alertOe_n}, 16'h1);
    wr(4'h2, 16'h0800);
    wr(4'h3, 16'h0100);
    wr(4'h5, 16'h0002);
    wr(4'h0, 16'h0001);
    firstIn <= 12'ha00 | 12'($urandom & 32'h1ff);
    conv(4'h4);
    settle;
    chk({15'h0, alertOe_n}, 16'h0);
    chk({15'h0, irq}, 16'h1);
    rd(4'h4, 16'h0002, 16'h0002);
    wr(4'h5, 16'h0000);
    @(negedge core_clk);
    chk({15'h0, irq}, 16'h0);
    wr(4'h5, 16'h0002);
    wr(4'h4, 16'h0007);
    @(negedge core_clk);
    chk({15'h0, irq}, 16'h0);
    for (i = 0; i < 2; i++) begin
      firstIn <= i ? 12'h050 : 12'h400;
      conv(4'h4);
      settle;
      chk({15'h0, alertOe_n}, i ? 16'h0 : 16'h1);
    end
    rd(4'hf, 16'hffff, 16'h0000);
    give_verdict;
  end
endmodule // testbench
